// ===== verification/rc_osc_trim_ctrl_bench.sv
// Self-checking testbench for the RC oscillator trim control block.
`timescale 1ns/1ps
`default_nettype none
module rc_osc_trim_ctrl_bench;
  import rc_osc_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic CLK_SYS, RST_N;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic OSC_POWER_DOWN, OSC_CAL_EN, OSC_REF_EN, OSC_REF_FULL, OSC_DIV_RST;
  logic [7:0] OSC_TRIM, CAL_CODE_IN;
  logic CAL_DONE_IN, CLK_RDY_IN, IRQ;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  rc_osc_trim_ctrl u_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .OSC_POWER_DOWN(OSC_POWER_DOWN), .OSC_TRIM(OSC_TRIM),
    .OSC_CAL_EN(OSC_CAL_EN), .OSC_REF_EN(OSC_REF_EN),
    .OSC_REF_FULL(OSC_REF_FULL), .OSC_DIV_RST(OSC_DIV_RST),
    .CAL_DONE_IN(CAL_DONE_IN), .CLK_RDY_IN(CLK_RDY_IN),
    .CAL_CODE_IN(CAL_CODE_IN), .IRQ(IRQ)
  );

  // ------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w) && n < 50) begin
      @(posedge CLK_SYS);
      n++;
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (BVALID !== 1'b1 && n < 50);
    BREADY <= 1'b0;
    check("bvalid", BVALID, 1'b1);
    check("bresp", BRESP, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er, input string nm);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (ARREADY !== 1'b1 && n < 50);
    ARVALID <= 1'b0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (RVALID !== 1'b1 && n < 50);
    RREADY <= 1'b0;
    check("rvalid", RVALID, 1'b1);
    check("rresp", RRESP, er);
    check(nm, RDATA, exp);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_CONTROL, 32'h0000_07F1, RESP_OKAY, "control");
    rd(OFF_STATE, 32'h0, RESP_OKAY, "state");
    rd(OFF_PENDING, 32'h0, RESP_OKAY, "pending");
    rd(OFF_MASK, 32'h0000_0003, RESP_OKAY, "mask");
    rd(OFF_RAW, 32'h0, RESP_OKAY, "raw");
    rd(OFF_REFCFG, 32'h0000_0004, RESP_OKAY, "refcfg");
    check("pwrdn", OSC_POWER_DOWN, 1'b0);
    check("calen", OSC_CAL_EN, 1'b0);
    check("refen", OSC_REF_EN, 1'b1);
    check("irq", IRQ, 1'b0);
    $display("reset values test done");
  endtask

  task automatic t_control();
    wr(OFF_CONTROL, 32'h0000_0A5E, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0000_0A5E, RESP_OKAY, "control");
    check("pwrdn", OSC_POWER_DOWN, 1'b1);
    check("trim", OSC_TRIM, 8'hA5);
    check("calen", OSC_CAL_EN, 1'b1);
    check("refen", OSC_REF_EN, 1'b0);
    wr(OFF_CONTROL, 32'h0000_0A51, RESP_OKAY);
    cyc(2);
    check("pwrdn", OSC_POWER_DOWN, 1'b0);
    check("trim", OSC_TRIM, 8'h00);
    check("calen", OSC_CAL_EN, 1'b0);
    check("refen", OSC_REF_EN, 1'b1);
    $display("control test done");
  endtask

  // The result code is set up two cycles before done rises, as asked.
  task automatic t_calib();
    wr(OFF_CONTROL, 32'h0000_07F3, RESP_OKAY);
    CAL_CODE_IN <= 8'h5C;
    cyc(2);
    CAL_DONE_IN <= 1'b1;
    cyc(6);
    rd(OFF_STATE, 32'h0000_0172, RESP_OKAY, "state");
    rd(OFF_RAW, 32'h1, RESP_OKAY, "raw");
    rd(OFF_PENDING, 32'h0, RESP_OKAY, "pending");
    check("irq", IRQ, 1'b0);
    check("trim", OSC_TRIM, 8'h5C);
    wr(OFF_MASK, 32'h2, RESP_OKAY);
    cyc(3);
    check("irq", IRQ, 1'b1);
    rd(OFF_PENDING, 32'h1, RESP_OKAY, "pending");
    CLK_RDY_IN <= 1'b1;
    cyc(6);
    rd(OFF_STATE, 32'h0000_0173, RESP_OKAY, "state");
    rd(OFF_RAW, 32'h3, RESP_OKAY, "raw");
    rd(OFF_PENDING, 32'h1, RESP_OKAY, "pending");
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    rd(OFF_PENDING, 32'h3, RESP_OKAY, "pending");
    wr(OFF_CLEAR, 32'h1, RESP_OKAY);
    rd(OFF_RAW, 32'h2, RESP_OKAY, "raw");
    cyc(2);
    check("irq", IRQ, 1'b1);
    wr(OFF_CLEAR, 32'h2, RESP_OKAY);
    rd(OFF_RAW, 32'h0, RESP_OKAY, "raw");
    cyc(2);
    check("irq", IRQ, 1'b0);
    rd(OFF_CLEAR, 32'h0, RESP_OKAY, "clear");
    $display("calibration and interrupt test done");
  endtask

  // Pins stay high, so a soft reset must lead to fresh rises and flags.
  task automatic t_sreset();
    wr(OFF_CONTROL, 32'h0000_0A5E, RESP_OKAY);
    wr(OFF_REFCFG, 32'h0000_0008, RESP_OKAY);
    cyc(2);
    check("divrst", OSC_DIV_RST, 1'b1);
    check("reffull", OSC_REF_FULL, 1'b0);
    wr(OFF_SRESET, 32'h0, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0000_0A5E, RESP_OKAY, "control");
    wr(OFF_SRESET, 32'h1, RESP_OKAY);
    cyc(1);
    rd(OFF_CONTROL, 32'h0000_07F1, RESP_OKAY, "control");
    rd(OFF_MASK, 32'h3, RESP_OKAY, "mask");
    rd(OFF_REFCFG, 32'h4, RESP_OKAY, "refcfg");
    check("divrst", OSC_DIV_RST, 1'b0);
    check("reffull", OSC_REF_FULL, 1'b1);
    check("pwrdn", OSC_POWER_DOWN, 1'b0);
    cyc(6);
    rd(OFF_RAW, 32'h3, RESP_OKAY, "raw");
    rd(OFF_SRESET, 32'h0, RESP_OKAY, "sreset");
    rd(8'h20, 32'h0, RESP_SLVERR, "unmapped");
    wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("soft reset test done");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    RST_N = 1'b0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    WDATA = 32'h0;
    WSTRB = 4'hF;
    CAL_DONE_IN = 1'b0;
    CLK_RDY_IN = 1'b0;
    CAL_CODE_IN = 8'h00;
    cyc(3);
    RST_N <= 1'b1;
    t_reset();
    t_control();
    t_calib();
    t_sreset();
    end_sim();
  end
endmodule
`default_nettype wire

// ===== verilog/cal_link_if.sv
// Synchronised oscillator status carried from the monitor to the core.
`timescale 1ns/1ps
`default_nettype none
interface cal_link_if;
  logic cal_done;
  logic clk_rdy;
  logic done_rise;
  logic rdy_rise;
  logic [7:0] code;
  modport mon (output cal_done, clk_rdy, done_rise, rdy_rise, code);
  modport core (input cal_done, clk_rdy, done_rise, rdy_rise, code);
endinterface
`default_nettype wire

// ===== verilog/cal_monitor.sv
// Two-stage synchronisers and rise detectors for the analog status pins.
`timescale 1ns/1ps
`default_nettype none
module cal_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Analog status pins
  input wire logic done_pin,
  input wire logic rdy_pin,
  input wire logic [7:0] code_pin,
  // Synchronised view
  cal_link_if.mon link
);
  logic [9:0] meta_reg;
  logic [9:0] sync_reg;
  logic [1:0] last_reg;

  // Only the second stage is looked at; the first stage stays private.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 10'h000;
      sync_reg <= 10'h000;
      last_reg <= 2'h0;
    end else begin
      meta_reg <= {code_pin, rdy_pin, done_pin};
      sync_reg <= meta_reg;
      last_reg <= sync_reg[1:0];
    end
  end

  assign link.cal_done = sync_reg[0];
  assign link.clk_rdy = sync_reg[1];
  assign link.code = sync_reg[9:2];
  assign link.done_rise = sync_reg[0] & ~last_reg[0];
  assign link.rdy_rise = sync_reg[1] & ~last_reg[1];
endmodule
`default_nettype wire

// ===== verilog/rc_osc_pkg.sv
// Constants shared by the RC oscillator trim control block.
package rc_osc_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_PENDING = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;
  localparam logic [7:0] OFF_REFCFG = 8'h18;
  localparam logic [7:0] OFF_SRESET = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_W = 14;
  localparam int CODE_W = 8;
  localparam int EXT_LSB = 4;
  localparam int PWRDN_BIT = 3;
  localparam int SEL_BIT = 2;
  localparam int CALEN_BIT = 1;
  localparam int REFEN_BIT = 0;
  localparam int ST_CODE_LSB = 2;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_RDY_BIT = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_RDY_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int REFCFG_W = 4;
  localparam int DIVRST_BIT = 3;
  localparam int REFSEL_BIT = 2;
  localparam int SRST_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] CONTROL_RST = 14'h07F1;
  localparam logic [1:0] MASK_RST = 2'h3;
  localparam logic [3:0] REFCFG_RST = 4'h4;
  localparam logic [7:0] EXT_CODE_RST = 8'h7F;
endpackage

// ===== verilog/rc_osc_trim_ctrl.sv
// Register file and trim control for the high-frequency RC oscillator.
// Notes on behaviour
// - external trim code in bits 11:4, resets 0x7F.
// - control bit 3 powers the oscillator down.
// - control bit 2 picks external over calibrated code.
// - control bit 1 enables calibration, resets zero.
// - control bit 0 enables reference clock, resets one.
// - state shows calibration done and resulting code.
// - state bit 0 shows oscillator clock ready.
// - pending bit 1 is raw ready, unmasked.
// - pending bit 0 is raw done, unmasked.
// - mask register resets to three, all masked.
// - mask bit one suppresses its interrupt.
// - raw register shows flags regardless of mask.
// - writing one to clear bit drops flag.
// - soft reset bit 0 resets whole block except the bus slave.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rc_osc_trim_ctrl (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite write address
  input wire logic [rc_osc_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [rc_osc_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Analog oscillator control
  output logic OSC_POWER_DOWN,
  output logic [7:0] OSC_TRIM,
  output logic OSC_CAL_EN,
  output logic OSC_REF_EN,
  output logic OSC_REF_FULL,
  output logic OSC_DIV_RST,
  // Analog oscillator status, asynchronous
  input wire logic CAL_DONE_IN,
  input wire logic CLK_RDY_IN,
  input wire logic [7:0] CAL_CODE_IN,
  // Interrupt
  output logic IRQ
);
  import rc_osc_pkg::*;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------
  logic soft_rst_reg;
  logic soft_rst_next;
  logic blk_rst_n;
  // The bus slave stays on the pin reset only, so the write that
  // triggers a soft reset still completes its response normally.
  assign blk_rst_n = RST_N & ~soft_rst_reg;
  cal_link_if link ();
  cal_monitor u_mon (
    .clk(CLK_SYS),
    .rst_n(blk_rst_n),
    .done_pin(CAL_DONE_IN),
    .rdy_pin(CLK_RDY_IN),
    .code_pin(CAL_CODE_IN),
    .link(link.mon)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic wr_hit;
  assign do_write = aw_full_reg & w_full_reg & ~BVALID;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wval = wdata_reg & wmask;
  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | wval;
  endfunction
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      AWREADY <= 1'b1;
      aw_full_reg <= 1'b0;
      waddr_reg <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_full_reg <= 1'b1;
        waddr_reg <= AWADDR;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      WREADY <= 1'b1;
      w_full_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_full_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        WREADY <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (waddr_reg)
      OFF_CONTROL, OFF_STATE, OFF_PENDING, OFF_MASK, OFF_RAW,
      OFF_CLEAR, OFF_REFCFG, OFF_SRESET: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end
  AST_BRESP_AFTER_BOTH: assert property (
    (aw_full_reg && w_full_reg && !BVALID) |=> BVALID && !AWREADY)
    else $error("write response missing after address and data");

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] control_reg;
  logic [IRQ_W-1:0] mask_reg;
  logic [REFCFG_W-1:0] refcfg_reg;
  logic [IRQ_W-1:0] raw_reg;
  logic [IRQ_W-1:0] raw_next;
  logic [IRQ_W-1:0] clr_pulse;
  logic [CODE_W-1:0] result_reg;
  logic [CODE_W-1:0] ext_code;
  assign ext_code = control_reg[EXT_LSB +: CODE_W];
  // Writable fields, including the reserved control bits 13:12.
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      control_reg <= CONTROL_RST;
    end else if (do_write && waddr_reg == OFF_CONTROL) begin
      control_reg <= CTRL_W'(merge({18'h0, control_reg}));
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      mask_reg <= MASK_RST;
    end else if (do_write && waddr_reg == OFF_MASK) begin
      mask_reg <= IRQ_W'(merge({30'h0, mask_reg}));
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      refcfg_reg <= REFCFG_RST;
    end else if (do_write && waddr_reg == OFF_REFCFG) begin
      refcfg_reg <= REFCFG_W'(merge({28'h0, refcfg_reg}));
    end
  end
  // Write-one pulse; the register itself reads back as zero.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= soft_rst_next;
    end
  end
  assign soft_rst_next = do_write && waddr_reg == OFF_SRESET &&
                         wval[SRST_BIT];
  sequence s_soft_write;
    do_write && waddr_reg == OFF_SRESET && wval[SRST_BIT];
  endsequence
  sequence s_block_reset;
    !blk_rst_n ##1 (control_reg == CONTROL_RST && mask_reg == MASK_RST);
  endsequence
  AST_SOFT_RESET: assert property (
    s_soft_write |=> s_block_reset)
    else $error("soft reset did not restore the register file");
  AST_SOFT_ZERO_NOP: assert property (
    (do_write && waddr_reg == OFF_SRESET && !wval[SRST_BIT])
      |=> blk_rst_n)
    else $error("soft reset written zero still reset the block");
  AST_MASK_RESET: assert property (
    !blk_rst_n |=> mask_reg == MASK_RST && !IRQ ##1 !IRQ)
    else $error("mask did not come out of reset fully set");

  // ----------------------------------------------------------------
  // Calibration result and event flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      result_reg <= '0;
    end else if (link.done_rise) begin
      result_reg <= link.code;
    end
  end
  assign clr_pulse = (do_write && waddr_reg == OFF_CLEAR) ?
                     wval[IRQ_W-1:0] : '0;
  // A rising event in the same cycle as its clear keeps the flag set.
  always_comb begin
    raw_next = raw_reg & ~clr_pulse;
    if (link.rdy_rise) begin
      raw_next[IRQ_RDY_BIT] = 1'b1;
    end
    if (link.done_rise) begin
      raw_next[IRQ_DONE_BIT] = 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= raw_next;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(raw_reg & ~mask_reg);
    end
  end
  AST_DONE_SETS_FLAG: assert property (
    (blk_rst_n && link.done_rise) |=> raw_reg[IRQ_DONE_BIT] &&
      result_reg == $past(link.code))
    else $error("calibration completion not recorded");
  AST_READY_SETS_FLAG: assert property (
    (blk_rst_n && link.rdy_rise) |=> raw_reg[IRQ_RDY_BIT])
    else $error("clock ready rise did not set its flag");
  AST_CLEAR_DROPS: assert property (
    (clr_pulse[IRQ_RDY_BIT] && !link.rdy_rise)
      |=> !raw_reg[IRQ_RDY_BIT])
    else $error("clear write left the ready flag set");
  AST_MASKED_QUIET: assert property (
    (mask_reg == MASK_RST) [*3] |-> !IRQ)
    else $error("interrupt raised while every source was masked");
  AST_IRQ_LEVEL: assert property (
    blk_rst_n |=> IRQ == $past(|(raw_reg & ~mask_reg)))
    else $error("interrupt output disagrees with unmasked flags");

  // ----------------------------------------------------------------
  // Oscillator control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!blk_rst_n) begin
      OSC_POWER_DOWN <= 1'b0;
      OSC_TRIM <= EXT_CODE_RST;
      OSC_CAL_EN <= 1'b0;
      OSC_REF_EN <= 1'b1;
      OSC_REF_FULL <= 1'b1;
      OSC_DIV_RST <= 1'b0;
    end else begin
      OSC_POWER_DOWN <= control_reg[PWRDN_BIT];
      OSC_TRIM <= control_reg[SEL_BIT] ?
                  ext_code : result_reg;
      OSC_CAL_EN <= control_reg[CALEN_BIT];
      OSC_REF_EN <= control_reg[REFEN_BIT];
      OSC_REF_FULL <= refcfg_reg[REFSEL_BIT];
      OSC_DIV_RST <= refcfg_reg[DIVRST_BIT];
    end
  end
  // Trim follows the source bit one cycle later; a block reset
  // overrides it for that cycle, so reset cycles are left out.
  AST_TRIM_SOURCE: assert property (
    blk_rst_n |=> OSC_TRIM == ($past(control_reg[SEL_BIT]) ?
                     $past(ext_code) : $past(result_reg)))
    else $error("trim output does not follow the selected source");
  AST_POWER_DOWN: assert property (
    $rose(control_reg[PWRDN_BIT]) |=> OSC_POWER_DOWN)
    else $error("power-down bit did not reach the oscillator");
  AST_CAL_ENABLE: assert property (
    (blk_rst_n && !control_reg[CALEN_BIT]) |=> !OSC_CAL_EN)
    else $error("calibration enabled while its bit is clear");
  AST_RESET_DEFAULTS: assert property (
    !blk_rst_n |=> OSC_REF_EN && ext_code == EXT_CODE_RST &&
                   !OSC_CAL_EN && !OSC_POWER_DOWN)
    else $error("control outputs wrong after reset");

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic rd_hit;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ARADDR)
      OFF_CONTROL: rd_data[CTRL_W-1:0] = control_reg;
      OFF_STATE: begin
        rd_data[ST_CODE_LSB +: CODE_W] = result_reg;
        rd_data[ST_DONE_BIT] = link.cal_done;
        rd_data[ST_RDY_BIT] = link.clk_rdy;
      end
      OFF_PENDING: rd_data[IRQ_W-1:0] = raw_reg & ~mask_reg;
      OFF_MASK: rd_data[IRQ_W-1:0] = mask_reg;
      OFF_RAW: rd_data[IRQ_W-1:0] = raw_reg;
      OFF_CLEAR, OFF_SRESET: rd_data = 32'h0000_0000;
      OFF_REFCFG: rd_data[REFCFG_W-1:0] = refcfg_reg;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_data;
      RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
    end
  end
  AST_READ_STATE: assert property (
    (ARVALID && ARREADY && ARADDR == OFF_STATE) |=>
      RVALID && RDATA[ST_RDY_BIT] == $past(link.clk_rdy) &&
      RDATA[ST_DONE_BIT] == $past(link.cal_done))
    else $error("state read does not show ready and done");
  AST_READ_RAW: assert property (
    (ARVALID && ARREADY && ARADDR == OFF_RAW) |=>
      RDATA[IRQ_W-1:0] == $past(raw_reg))
    else $error("raw flags read back masked");
endmodule
`default_nettype wire
